// [core/adsq_control.sv]
/*
 Converter sequencer control: calibration, channel sequencing, result
 and injection registers, overrun handling, register port.
 Assumes an analog core that takes a start pulse and answers with a
 done pulse and a 10-bit value; register port is synchronous.
*/
`timescale 1ns/1ps
module adsq_control
#(
	parameter int CAL_LEN = adsq_pkg::CAL_CYCLES,
	parameter int NCH = 24
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic [15:0] port5Pins,
	input wire logic [7:0] port1Pins,
	input wire logic [7:0] altPortPins,
	input wire logic anaDone,
	input wire logic [9:0] anaValue,
	output logic anaSample,
	output logic anaStart,
	output logic [4:0] anaChan,
	output logic extraFromAlt,
	output logic ovrIrq,
	output logic resultReq,
	output logic injReq,
	output logic busyFlag
);
	import adsq_pkg::*;

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rstMeta_ff;
	logic rstSync_ff;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end
		else
		begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end
	wire logic rstn = rstSync_ff;

	function automatic logic [4:0] nextChan(input logic [4:0] c);
		nextChan = (c == 5'h0) ? 5'h0 : c - 5'h1;
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [15:0] control_ff;
	logic [15:0] timing_ff;
	logic extraSel_ff;
	logic [15:0] result_ff;
	logic [15:0] tempBuf_ff;
	logic tempFull_ff;
	logic resultUnread_ff;
	logic overrun_ff;
	logic [15:0] injResult_ff;
	logic injPending_ff;
	logic injActive_ff;
	logic [4:0] curChan_ff;
	logic [16:0] calCnt_ff;
	logic [7:0] phaseCnt_ff;
	adsq_state_t state_ff;
	logic [15:0] nxt_rdata;

	wire logic [4:0] selChan = control_ff[CTL_CHAN_LSB +: 5];
	wire logic [1:0] mode = control_ff[CTL_MODE_LSB +: 2];
	wire logic waitRd = control_ff[CTL_WAITRD_BIT];
	wire logic ovrStall = control_ff[CTL_OVRSTALL_BIT];
	wire logic contMode = mode[0];
	wire logic scanMode = mode[1];
	wire logic resultRead = regRd && regAddr == OFF_RESULT;
	wire logic storeNow = state_ff == ST_STORE;
	// In the continuous modes wait-for-read lets one more conversion run into the temporary buffer
	wire logic blocked = resultUnread_ff && ovrStall;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			control_ff <= CONTROL_RST;
			timing_ff <= TIMING_RST;
			extraSel_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			if (regWr && regAddr == OFF_CONTROL)
				control_ff <= regWdata;
			else if (storeNow && !injActive_ff && !contMode && (!scanMode || curChan_ff == 5'h0))
				control_ff[CTL_START_BIT] <= 1'b0;
			if (regWr && regAddr == OFF_TIMING)
				timing_ff <= regWdata;
			if (regWr && regAddr == OFF_XBUSCFG)
				extraSel_ff <= regWdata[0];
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff <= ST_CAL;
			calCnt_ff <= 17'h0;
			phaseCnt_ff <= 8'h0;
			curChan_ff <= 5'h0;
			injActive_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			unique case (state_ff)
				ST_CAL:
				begin
					calCnt_ff <= calCnt_ff + 17'h1;
					if (calCnt_ff == 17'(CAL_LEN - 1))
						state_ff <= ST_IDLE;
				end
				ST_IDLE:
				begin
					phaseCnt_ff <= 8'h0;
					if (injPending_ff && contMode && control_ff[CTL_START_BIT])
					begin
						injActive_ff <= 1'b1;
						state_ff <= ST_SAMPLE;
					end
					else if (control_ff[CTL_START_BIT] && !blocked && !tempFull_ff)
					begin
						state_ff <= ST_SAMPLE;
					end
				end
				ST_SAMPLE:
				begin
					phaseCnt_ff <= phaseCnt_ff + 8'h1;
					if (phaseCnt_ff >= timing_ff[7:0])
						state_ff <= ST_CONVERT;
				end
				ST_CONVERT:
				begin
					phaseCnt_ff <= phaseCnt_ff + 8'h1;
					if (anaDone && phaseCnt_ff >= timing_ff[15:8])
						state_ff <= ST_STORE;
				end
				ST_STORE:
				begin
					if (injActive_ff)
						injActive_ff <= 1'b0;
					else if (scanMode)
						curChan_ff <= (curChan_ff == 5'h0) ? selChan : nextChan(curChan_ff);
					state_ff <= ST_IDLE;
				end
				ST_HOLD:
					state_ff <= ST_IDLE;
				default:
					state_ff <= ST_IDLE;
			endcase
			if (regWr && regAddr == OFF_CONTROL && !regWdata[CTL_INJREQ_BIT])
				curChan_ff <= regWdata[CTL_CHAN_LSB +: 5]; // Start and top channel land together
			else if (state_ff == ST_IDLE && !scanMode)
				curChan_ff <= selChan;
			else if (state_ff == ST_IDLE && !control_ff[CTL_START_BIT])
				curChan_ff <= selChan; // Scan runs from the top channel down to zero
		end
	end

	// ----------------------------------------------------------------
	// Results, overrun, wait-for-read and injection
	// ----------------------------------------------------------------
	wire logic [15:0] newResult = {1'b0, curChan_ff, anaValue};
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			result_ff <= 16'h0;
			tempBuf_ff <= 16'h0;
			tempFull_ff <= 1'b0;
			resultUnread_ff <= 1'b0;
			overrun_ff <= 1'b0;
			injResult_ff <= 16'h0;
			injPending_ff <= 1'b0;
		end
		else if (clkEn)
		begin
			if (storeNow && injActive_ff)
			begin
				injResult_ff[9:0] <= anaValue;
				injPending_ff <= 1'b0;
			end
			else if (storeNow && waitRd && contMode && resultUnread_ff && !resultRead)
			begin
				tempBuf_ff <= newResult;
				tempFull_ff <= 1'b1;
			end
			else if (storeNow)
			begin
				result_ff <= newResult;
				resultUnread_ff <= 1'b1;
				if (resultUnread_ff && !resultRead)
					overrun_ff <= 1'b1;
			end
			else if (resultRead && tempFull_ff)
			begin
				result_ff <= tempBuf_ff;
				tempFull_ff <= 1'b0;
			end
			else if (resultRead)
				resultUnread_ff <= 1'b0;
			// A new request wins over the one retiring in the same cycle
			if (regWr && regAddr == OFF_CONTROL && regWdata[CTL_INJREQ_BIT])
			begin
				injPending_ff <= 1'b1;
				injResult_ff[15:10] <= {1'b0, regWdata[CTL_INJCHAN_LSB +: 5]};
			end
			if (regRd && regAddr == OFF_STATUS && !(storeNow && resultUnread_ff))
				overrun_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all registered
	// ----------------------------------------------------------------
	wire logic [4:0] convChan = injActive_ff ? injResult_ff[14:10] : curChan_ff;
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			anaSample <= 1'b0;
			anaStart <= 1'b0;
			anaChan <= 5'h0;
			extraFromAlt <= 1'b0;
			ovrIrq <= 1'b0;
			resultReq <= 1'b0;
			injReq <= 1'b0;
			busyFlag <= 1'b1;
		end
		else if (clkEn)
		begin
			anaSample <= state_ff == ST_SAMPLE;
			anaStart <= state_ff == ST_SAMPLE && phaseCnt_ff >= timing_ff[7:0];
			anaChan <= convChan;
			extraFromAlt <= extraSel_ff;
			ovrIrq <= overrun_ff && !ovrStall;
			resultReq <= storeNow && !injActive_ff && scanMode;
			injReq <= storeNow && injActive_ff;
			busyFlag <= state_ff == ST_CAL && calCnt_ff != 17'(CAL_LEN - 1);
		end
	end

	// ----------------------------------------------------------------
	// Register read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_rdata = 16'h0;
		unique case (regAddr)
			OFF_CONTROL: nxt_rdata = control_ff;
			OFF_RESULT: nxt_rdata = result_ff;
			OFF_INJRESULT: nxt_rdata = injResult_ff;
			OFF_TIMING: nxt_rdata = timing_ff;
			OFF_XBUSCFG: nxt_rdata = {15'h0, extraSel_ff};
			OFF_STATUS: nxt_rdata = {11'h0, injPending_ff, tempFull_ff, overrun_ff,
				state_ff == ST_CAL, state_ff == ST_CAL};
			OFF_DIGIN: nxt_rdata = extraSel_ff ? {altPortPins, port5Pins[7:0]}
				: {port1Pins, port5Pins[7:0]};
			default: nxt_rdata = 16'h0;
		endcase
	end
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			regRdata <= 16'h0;
		else if (clkEn)
			regRdata <= regRd ? nxt_rdata : 16'h0;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence calEnd;
		state_ff == ST_CAL ##1 state_ff == ST_IDLE;
	endsequence
	chk_busy_cal: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && state_ff == ST_CAL && calCnt_ff < 17'(CAL_LEN - 1) |=> busyFlag)
		else $error("busy low during calibration");
	chk_busy_clear: assert property (@(posedge clock) disable iff (!rstn)
		calEnd |-> !busyFlag)
		else $error("busy still set after calibration");
	chk_no_start_cal: assert property (@(posedge clock) disable iff (!rstn)
		busyFlag |-> !anaStart)
		else $error("conversion started during calibration");
	chk_cal_bound: assert property (@(posedge clock) disable iff (!rstn)
		calCnt_ff <= 17'(CAL_LEN))
		else $error("calibration overran its bound");
	chk_ovr_flag: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && storeNow && !injActive_ff && resultUnread_ff && !resultRead
		&& !(waitRd && contMode) |=> overrun_ff)
		else $error("overrun not flagged");
	chk_stall_hold: assert property (@(posedge clock) disable iff (!rstn)
		state_ff == ST_IDLE && blocked && !injPending_ff |=> state_ff != ST_SAMPLE)
		else $error("conversion started while stalled");
	chk_wait_hold: assert property (@(posedge clock) disable iff (!rstn)
		state_ff == ST_IDLE && tempFull_ff && !injPending_ff |=> state_ff != ST_SAMPLE)
		else $error("conversion started with buffer full");
	chk_inj_store: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && storeNow && injActive_ff |=> injResult_ff[9:0] == $past(anaValue) && injReq)
		else $error("injection result not stored");
	chk_scan_req: assert property (@(posedge clock) disable iff (!rstn)
		clkEn && storeNow && !injActive_ff && scanMode |=> resultReq)
		else $error("scan request missing");
endmodule

// [core/adsq_pkg.sv]
/*
 Package for the converter sequencer control: register offsets, field
 positions, reset values, mode and state encodings, timing counts.
 Assumes a single 100 MHz clock domain.
*/
package adsq_pkg;
	// ----------------------------------------------------------------
	// Register offsets (word index on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_RESULT = 4'h1;
	localparam logic [3:0] OFF_INJRESULT = 4'h2;
	localparam logic [3:0] OFF_TIMING = 4'h3;
	localparam logic [3:0] OFF_XBUSCFG = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h5;
	localparam logic [3:0] OFF_DIGIN = 4'h6;
	// ----------------------------------------------------------------
	// Register fields and reset values
	// ----------------------------------------------------------------
	localparam int CTL_CHAN_LSB = 0;
	localparam int CTL_MODE_LSB = 5;
	localparam int CTL_START_BIT = 7;
	localparam int CTL_WAITRD_BIT = 8;
	localparam int CTL_OVRSTALL_BIT = 9;
	localparam int CTL_INJREQ_BIT = 10;
	localparam int CTL_INJCHAN_LSB = 11;
	localparam int RES_CHAN_LSB = 10;
	localparam int STS_BUSY_BIT = 0;
	localparam int STS_CAL_BIT = 1;
	localparam int STS_OVR_BIT = 2;
	localparam int STS_HOLD_BIT = 3;
	localparam int STS_INJ_BIT = 4;
	localparam logic [15:0] CONTROL_RST = 16'h0000;
	localparam logic [15:0] TIMING_RST = 16'h0808;
	// ----------------------------------------------------------------
	// Conversion modes and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h1;
	localparam logic [1:0] MODE_SCAN = 2'h2;
	localparam logic [1:0] MODE_SCANCONT = 2'h3;
	localparam int CAL_CPU_CYCLES = 40630;
	localparam int CLOCK_MHZ = 100;
	localparam int CPU_MHZ = 64;
	localparam int CAL_CYCLES = (CAL_CPU_CYCLES * CLOCK_MHZ) / CPU_MHZ;
	typedef enum logic [2:0]
	{
		ST_CAL = 3'b000,
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b011,
		ST_STORE = 3'b100,
		ST_HOLD = 3'b101
	} adsq_state_t;
endpackage

// [verification/adsq_testbench.sv]
/*
 Self-checking testbench for adsq_control: register port tasks, a simple
 analog core responder and one task per scenario.
 Assumes the adsq_pkg package and a single 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
	import adsq_pkg::*;
	// --------------------------------------------------------------
	// Signals and instance
	// --------------------------------------------------------------
	localparam int CAL = 20;
	logic clock, resetn, regWr, regRd, clkEn;
	logic anaDone = 1'b0;
	logic [9:0] anaValue = 10'h000;
	logic [3:0] regAddr;
	logic [15:0] regWdata, regRdata, port5Pins, rd;
	logic [7:0] port1Pins, altPortPins;
	logic anaSample, anaStart, extraFromAlt, ovrIrq, resultReq, injReq, busyFlag;
	logic [4:0] anaChan;
	int n_mismatch = 0;
	int num_checks = 0;
	int nStarts = 0;
	int nRes = 0;
	int nInj = 0;
	int cyc = 0;
	int doneCnt = 0;
	int s, k, r;
	logic [4:0] chanQ[$];
	adsq_control #(.CAL_LEN(CAL)) dut (.clock(clock), .resetn(resetn), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .port5Pins(port5Pins), .port1Pins(port1Pins),
		.altPortPins(altPortPins), .anaDone(anaDone), .anaValue(anaValue),
		.anaSample(anaSample), .anaStart(anaStart), .anaChan(anaChan),
		.extraFromAlt(extraFromAlt), .ovrIrq(ovrIrq), .resultReq(resultReq),
		.injReq(injReq), .busyFlag(busyFlag));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// --------------------------------------------------------------
	// Analog core stand-in: done three cycles after each start
	// --------------------------------------------------------------
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (anaStart === 1'b1)
		begin
			nStarts++;
			chanQ.push_back(anaChan);
			anaValue <= {5'h15, anaChan};
			anaDone <= 1'b0;
			doneCnt <= 3;
		end
		else
		begin
			// Done is a one-cycle pulse, so a stale done cannot end the next conversion
			if (doneCnt != 0)
				doneCnt <= doneCnt - 1;
			anaDone <= (doneCnt == 1);
		end
		if (resultReq === 1'b1) nRes++;
		if (injReq === 1'b1) nInj++;
		// Whole run needs about 1000 cycles
		if (cyc > 6000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic drain();
		wr(OFF_CONTROL, 16'h0000);
		idle(30);
		rdr(OFF_STATUS);
		rdr(OFF_RESULT);
		rdr(OFF_RESULT);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_cal();
		k = 0;
		#1 check(16'(busyFlag), 16'h1, "busy at release");
		while (busyFlag === 1'b1 && k < CAL + 10)
		begin
			@(posedge clock);
			#1 k++;
		end
		check(16'(k <= CAL + 4), 16'h1, "calibration too long");
		check(16'(k >= CAL), 16'h1, "calibration too short");
		rdr(OFF_STATUS);
		check(rd[1:0], 16'h0, "busy and cal bits after calibration");
		$display("test calibration done");
	endtask
	task automatic t_regs();
		rdr(OFF_TIMING);
		check(rd, TIMING_RST, "timing reset value");
		wr(OFF_TIMING, 16'h0302);
		rdr(OFF_TIMING);
		check(rd, 16'h0302, "timing readback");
		wr(4'hf, 16'hffff);
		rdr(4'hf);
		check(rd, 16'h0000, "unmapped read");
		rdr(OFF_CONTROL);
		check(rd, CONTROL_RST, "control reset value");
		for (int i = 0; i < 2; i++)
		begin
			wr(OFF_XBUSCFG, 16'(i));
			rdr(OFF_DIGIN);
			check(rd, {(i == 1) ? 8'h9a : 8'h56, 8'h34}, "digital inputs");
			check(16'(extraFromAlt), 16'(i), "extra group select");
		end
		wr(OFF_XBUSCFG, 16'h0000);
		$display("test registers done");
	endtask
	task automatic t_single();
		s = nStarts;
		wr(OFF_CONTROL, 16'h0085);
		idle(40);
		check(16'(nStarts - s), 16'h1, "single shot start count");
		check(16'(chanQ[$]), 16'h5, "single shot channel");
		rdr(OFF_RESULT);
		check({1'b0, rd[14:0]}, {1'b0, 5'h05, 5'h15, 5'h05}, "single result");
		rdr(OFF_CONTROL);
		check(16'(rd[7]), 16'h0, "start bit cleared");
		$display("test single done");
	endtask
	task automatic t_overrun();
		s = nStarts;
		wr(OFF_CONTROL, 16'h00a3);
		idle(60);
		check(16'(ovrIrq), 16'h1, "overrun request");
		check(16'(nStarts - s > 2), 16'h1, "continuous repeats");
		drain();
		idle(2);
		check(16'(ovrIrq), 16'h0, "overrun cleared");
		$display("test overrun done");
	endtask
	task automatic t_hold(input int b);
		wr(OFF_CONTROL, 16'h00a3 | (16'h0001 << b));
		idle(60);
		s = nStarts;
		idle(40);
		check(16'(nStarts - s), 16'h0, "held without read");
		rdr(OFF_RESULT);
		idle(40);
		check(16'(nStarts > s), 16'h1, "resumed after read");
		drain();
		$display("test hold done");
	endtask
	task automatic t_scan();
		chanQ.delete();
		r = nRes;
		wr(OFF_CONTROL, 16'h00c2);
		idle(80);
		check(16'(chanQ.size()), 16'h3, "scan conversion count");
		for (int i = 0; i < 3; i++)
			check(16'(chanQ[i]), 16'(2 - i), "scan channel order");
		check(16'(nRes - r), 16'h3, "scan transfer requests");
		drain();
		r = nRes;
		wr(OFF_CONTROL, 16'h00e1);
		idle(100);
		check(16'(nRes - r > 5), 16'h1, "scan repeats");
		drain();
		$display("test scan done");
	endtask
	task automatic t_inject();
		wr(OFF_CONTROL, 16'h00a3);
		idle(30);
		r = nInj;
		k = 0;
		wr(OFF_CONTROL, 16'h3ca3);
		while (nInj == r && k < 200)
		begin
			@(posedge clock);
			k++;
		end
		check(16'(nInj - r), 16'h1, "injection request");
		idle(5);
		rdr(OFF_INJRESULT);
		check({1'b0, rd[14:0]}, {1'b0, 5'h07, 5'h15, 5'h07}, "injection result");
		rdr(OFF_CONTROL);
		check({8'h00, rd[7:0]}, 16'h00a3, "mode kept");
		s = nStarts;
		idle(40);
		check(16'(nStarts > s), 16'h1, "continuous resumed");
		drain();
		$display("test inject done");
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		resetn = 1'b0;
		clkEn = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		port5Pins = 16'h1234;
		port1Pins = 8'h56;
		altPortPins = 8'h9a;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		t_cal();
		t_regs();
		t_single();
		t_overrun();
		t_hold(CTL_OVRSTALL_BIT);
		t_hold(CTL_WAITRD_BIT);
		t_scan();
		t_inject();
		end_sim();
	end
endmodule
